/* src/tw_pkg.sv */
// Purpose: constants and types of the two-wire bus controller
// Assumes: pclk at 250 MHz, 32-bit APB register slots
// Notes: byte addresses within a 4 KB slot
package tw_pkg;
  localparam int TW_AW = 12;
  // register byte offsets
  localparam logic [11:0] TW_CTRL = 12'h000;
  localparam logic [11:0] TW_CMD = 12'h004;
  localparam logic [11:0] TW_OWN1 = 12'h008;
  localparam logic [11:0] TW_OWN2 = 12'h00C;
  localparam logic [11:0] TW_TIME = 12'h010;
  localparam logic [11:0] TW_TOUT = 12'h014;
  localparam logic [11:0] TW_STAT = 12'h018;
  localparam logic [11:0] TW_MASK = 12'h01C;
  localparam logic [11:0] TW_TXD = 12'h020;
  localparam logic [11:0] TW_RXD = 12'h024;
  localparam logic [11:0] TW_PEC = 12'h028;
  // control fields
  localparam int TW_C_EN = 0;
  localparam int TW_C_ANF = 1;
  localparam int TW_C_DNF = 2;
  localparam int TW_C_FMP = 6;
  localparam int TW_C_WUP = 7;
  localparam int TW_C_HOST = 8;
  localparam int TW_C_DEV = 9;
  localparam int TW_C_ARA = 10;
  localparam int TW_C_PECEN = 11;
  localparam int TW_C_ALRT = 12;
  // command and own-address fields
  localparam int TW_M_TEN = 10;
  localparam int TW_M_RD = 11;
  localparam int TW_M_NBY = 12;
  localparam int TW_M_GO = 20;
  localparam int TW_O_TEN = 10;
  localparam int TW_O_MSK = 8;
  localparam int TW_O_EN = 15;
  // status bits, sticky then live
  localparam int TW_S_ADDR = 0;
  localparam int TW_S_RXNE = 1;
  localparam int TW_S_TXE = 2;
  localparam int TW_S_NACK = 3;
  localparam int TW_S_ARLO = 4;
  localparam int TW_S_STOP = 5;
  localparam int TW_S_PECE = 6;
  localparam int TW_S_TOUT = 7;
  localparam int TW_S_ALRT = 8;
  localparam int TW_NS = 9;
  localparam int TW_S_BUSY = 16;
  // bus rates and half bit times
  localparam int TW_PCLK_HZ = 250_000_000;
  localparam int TW_STD_BPS = 100_000;
  localparam int TW_FAST_BPS = 400_000;
  localparam int TW_FMP_BPS = 1_000_000;
  localparam logic [15:0] TW_HALF_STD = 16'(TW_PCLK_HZ / (2 * TW_STD_BPS));
  localparam logic [15:0] TW_HALF_FAST = 16'(TW_PCLK_HZ / (2 * TW_FAST_BPS));
  localparam logic [15:0] TW_HALF_FMP = 16'(TW_PCLK_HZ / (2 * TW_FMP_BPS));
  localparam logic [11:0] TW_TOUT_RST = 12'h000;
  // smbus reserved addresses and 10-bit header
  localparam logic [6:0] TW_A_HOST = 7'h08;
  localparam logic [6:0] TW_A_DEV = 7'h61;
  localparam logic [6:0] TW_A_ARA = 7'h0C;
  localparam logic [4:0] TW_HDR10 = 5'h1E;
  localparam logic [7:0] TW_POLY = 8'h07;
  typedef enum logic [1:0] {TW_A1 = 2'b00, TW_A2 = 2'b01, TW_DAT = 2'b10, TW_ARD = 2'b11} tw_ph_t;
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000, TW_START = 3'b001, TW_LOW = 3'b010, TW_HIGH = 3'b011,
    TW_STOP = 3'b100, TW_RST = 3'b101, TW_SLV = 3'b110, TW_WAIT = 3'b111
  } tw_eng_t;
endpackage : tw_pkg

/* src/tw_ctrl.sv */
// Purpose: two-wire bus controller, master and slave, APB registers
// Assumes: pins pass two flip-flops; pclk also serves as kernel clock
// Notes: analog filter lives in the pad, anf_en steers it
// What this block does
// - acts as arbitrating multi-master bus master or as addressed slave
// - standard 100 kbit/s and fast 400 kbit/s via programmable half period
// - only primary instance drives fast-plus strong outputs
// - 7-bit and 10-bit addressing as master and as slave
// - two own addresses, second compared under mask
// - digital filter drops spikes of 1 to 15 clocks
// - analog filter enable stays active in stop mode
// - no stop wakeup while digital filter enabled
// - primary has smbus: arp, host notify, pec, timeout, alert
// - primary detects own address in stop and wakes system
// - primary requests fast rc oscillator in stop while the bus is busy
// - dma requests for transmit and receive bytes
module tw_ctrl #(
  parameter bit PRIMARY = 1'b1 // primary instance features
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [tw_pkg::TW_AW-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic scl_i, // clock pin in
  output logic scl_o, // clock pin out
  output logic scl_oe, // clock pin drive
  input wire logic sda_i, // data pin in
  output logic sda_o, // data pin out
  output logic sda_oe, // data pin drive
  input wire logic smba_i, // alert pin in
  output logic smba_o, // alert pin out
  output logic smba_oe, // alert pin drive
  input wire logic stop_mode, // system in stop
  output logic irq, // interrupt
  output logic dma_tx_req, // dma transmit
  output logic dma_rx_req, // dma receive
  output logic wakeup, // stop wakeup
  output logic osc_req, // fast rc request
  output logic fmp_drive, // strong drive
  output logic anf_en // analog filter on
);
  import tw_pkg::*;

  typedef struct packed {
    logic rdy, err;
    logic [31:0] rd;
    logic [2:0] s1, s2;
    logic [1:0][3:0] fcnt;
    logic [1:0] flt, fltd;
    logic smbd;
    logic [12:0] ctl;
    logic [3:0] dnf;
    logic anf;
    logic [9:0] tadr;
    logic tten, trd;
    logic [7:0] nby;
    logic [15:0] own1, own2, half;
    logic [11:0] tout, tdiv, tcnt;
    logic [TW_NS-1:0] sts, msk;
    logic [7:0] txd, rxd, sh, crc;
    logic txf, rxf;
    tw_eng_t eng;
    tw_ph_t ph;
    logic mst, xmit, busy, tenhit, hold, rcvd, rxany;
    logic [3:0] cnt;
    logic [15:0] tmr;
    logic scloe, sdaoe, smbaoe, irq, dtx, drx, wake, osc, fmp;
  } tw_state_t;

  tw_state_t st_reg, st_next;

  // pec step over one bit
  function automatic logic [7:0] tw_crc(input logic [7:0] c, input logic b);
    tw_crc = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? TW_POLY : 8'h00);
  endfunction : tw_crc

  // data line wanted low for the current bit
  function automatic logic tw_sda(input tw_state_t s);
    if (s.cnt == 4'h8) tw_sda = !s.xmit && !(s.mst && s.ph == TW_DAT && s.nby == 8'h01);
    else tw_sda = s.xmit && !s.sh[7];
  endfunction : tw_sda

  // whole next state
  always_comb begin
    logic acc, rise, fall, sdet, pdet, b, hit, ld, dx, stall, tdone;
    logic [7:0] shn;
    logic [6:0] m7;
    logic [TW_NS-1:0] ev, clr;
    acc = psel && penable && st_reg.rdy;
    rise = 1'b0;
    fall = 1'b0;
    sdet = 1'b0;
    pdet = 1'b0;
    b = st_reg.flt[1];
    hit = 1'b0;
    ld = 1'b0;
    dx = 1'b0;
    tdone = st_reg.tmr >= st_reg.half;
    stall = st_reg.hold || (st_reg.cnt == 4'h8 && !st_reg.xmit && st_reg.ph == TW_DAT && !st_reg.rcvd);
    shn = {st_reg.sh[6:0], st_reg.flt[1]};
    m7 = 7'((8'h01 << st_reg.own2[10:8]) - 8'h01);
    ev = '0;
    clr = '0;
    st_next = st_reg;
    // pin synchronisers and digital filter
    st_next.s1 = {smba_i, sda_i, scl_i};
    st_next.s2 = st_reg.s1;
    for (int i = 0; i < 2; i++) begin
      if (st_reg.dnf == 4'h0 || st_reg.s2[i] == st_reg.flt[i]) begin
        st_next.flt[i] = st_reg.s2[i];
        st_next.fcnt[i] = 4'h0;
      end else if (st_reg.fcnt[i] == st_reg.dnf) begin
        st_next.flt[i] = st_reg.s2[i];
        st_next.fcnt[i] = 4'h0;
      end else begin
        st_next.fcnt[i] = st_reg.fcnt[i] + 4'h1;
      end
    end
    st_next.fltd = st_reg.flt;
    rise = st_reg.flt[0] && !st_reg.fltd[0];
    fall = !st_reg.flt[0] && st_reg.fltd[0];
    sdet = st_reg.flt[0] && st_reg.fltd[0] && !st_reg.flt[1] && st_reg.fltd[1];
    pdet = st_reg.flt[0] && st_reg.fltd[0] && st_reg.flt[1] && !st_reg.fltd[1];
    // bus busy and stop handling
    if (sdet) st_next.busy = 1'b1;
    if (pdet) begin
      st_next.busy = 1'b0;
      ev[TW_S_STOP] = 1'b1;
      ev[TW_S_PECE] = PRIMARY && st_reg.ctl[TW_C_PECEN] && st_reg.rxany && st_reg.crc != 8'h00;
      if (st_reg.eng == TW_SLV || st_reg.eng == TW_WAIT) st_next.eng = TW_IDLE;
    end
    // slave takes the bus on a foreign start
    if (sdet && !st_reg.mst && st_reg.ctl[TW_C_EN]) begin
      st_next.eng = TW_SLV;
      st_next.cnt = 4'h0;
      st_next.ph = TW_A1;
      st_next.xmit = 1'b0;
      st_next.crc = 8'h00;
      st_next.rxany = 1'b0;
      st_next.hold = 1'b0;
      if (st_reg.eng != TW_SLV) st_next.tenhit = 1'b0;
    end
    // address match as slave
    hit = (st_reg.own1[TW_O_EN] && !st_reg.own1[TW_O_TEN] && shn[7:1] == st_reg.own1[6:0]) ||
          (st_reg.own2[TW_O_EN] && ((shn[7:1] ^ st_reg.own2[7:1]) & ~m7) == 7'h00) ||
          (PRIMARY && ((st_reg.ctl[TW_C_HOST] && shn[7:1] == TW_A_HOST) ||
          (st_reg.ctl[TW_C_DEV] && shn[7:1] == TW_A_DEV) ||
          (st_reg.ctl[TW_C_ARA] && shn[7:1] == TW_A_ARA)));
    if (st_reg.own1[TW_O_EN] && st_reg.own1[TW_O_TEN] && shn[7:3] == TW_HDR10 &&
        shn[2:1] == st_reg.own1[9:8] && (!shn[0] || st_reg.tenhit)) hit = 1'b1;
    if (st_reg.ph == TW_A2) hit = shn == st_reg.own1[7:0];
    // master bit timing and slave line drive
    unique case (st_reg.eng)
      TW_START: begin
        st_next.sdaoe = 1'b1;
        st_next.tmr = st_reg.tmr + 16'h1;
        if (tdone) begin
          st_next.eng = TW_LOW;
          st_next.cnt = 4'h0;
          st_next.tmr = 16'h0;
        end
      end
      TW_LOW: begin
        st_next.scloe = 1'b1;
        if (st_reg.tmr == 16'h1) st_next.sdaoe = tw_sda(st_reg);
        if (!stall) st_next.tmr = st_reg.tmr + 16'h1;
        if (!stall && tdone) begin
          st_next.eng = TW_HIGH;
          st_next.tmr = 16'h0;
        end
      end
      TW_HIGH: begin
        st_next.scloe = 1'b0;
        if (st_reg.flt[0]) st_next.tmr = st_reg.tmr + 16'h1;
      end
      TW_RST, TW_STOP: begin
        st_next.scloe = st_reg.cnt == 4'h0;
        if (st_reg.tmr == 16'h1) st_next.sdaoe = st_reg.eng == TW_STOP;
        if (st_reg.cnt == 4'h0 || st_reg.flt[0]) st_next.tmr = st_reg.tmr + 16'h1;
        if (tdone) begin
          st_next.tmr = 16'h0;
          st_next.cnt = 4'h1;
          if (st_reg.cnt != 4'h0) begin
            st_next.cnt = 4'h0;
            st_next.sdaoe = st_reg.eng == TW_RST;
            st_next.eng = st_reg.eng == TW_RST ? TW_START : TW_IDLE;
            if (st_reg.eng == TW_STOP) st_next.mst = 1'b0;
          end
        end
      end
      TW_SLV: begin
        if (!st_reg.flt[0]) st_next.sdaoe = tw_sda(st_reg);
        st_next.scloe = stall && (st_reg.scloe || !st_reg.flt[0]);
      end
      default: begin
        st_next.scloe = 1'b0;
        if (st_reg.eng != TW_WAIT || !st_reg.mst) st_next.sdaoe = 1'b0;
      end
    endcase
    // bit sample: master at end of high, slave at rising edge
    if ((st_reg.eng == TW_HIGH && st_reg.flt[0] && tdone) || (st_reg.eng == TW_SLV && rise && !sdet)) begin
      st_next.tmr = 16'h0;
      if (st_reg.mst) st_next.eng = TW_LOW;
      if (st_reg.cnt != 4'h8) begin
        if (st_reg.mst && st_reg.xmit && st_reg.sh[7] && !b) begin
          ev[TW_S_ARLO] = 1'b1;
          st_next.mst = 1'b0;
          st_next.eng = TW_WAIT;
          st_next.sdaoe = 1'b0;
        end else begin
          st_next.sh = shn;
          st_next.crc = tw_crc(st_reg.crc, b);
          st_next.cnt = st_reg.cnt + 4'h1;
          st_next.rcvd = 1'b0;
          if (!st_reg.mst && st_reg.cnt == 4'h7 && st_reg.ph != TW_DAT) begin
            if (!hit) st_next.eng = TW_WAIT;
            if (hit) ev[TW_S_ADDR] = 1'b1;
            if (hit && PRIMARY && stop_mode && st_reg.ctl[TW_C_WUP] && st_reg.dnf == 4'h0) st_next.wake = 1'b1;
          end
        end
      end else begin
        st_next.cnt = 4'h0;
        if (st_reg.xmit && b) begin
          ev[TW_S_NACK] = 1'b1;
          st_next.eng = st_reg.mst ? TW_STOP : TW_WAIT;
        end else begin
          unique case (st_reg.ph)
            TW_A1: begin
              if (st_reg.mst && st_reg.tten) begin
                st_next.ph = TW_A2;
                st_next.sh = st_reg.tadr[7:0];
              end else if (!st_reg.mst && st_reg.sh[7:3] == TW_HDR10 && !st_reg.sh[0]) begin
                st_next.ph = TW_A2;
              end else begin
                st_next.ph = TW_DAT;
                dx = st_reg.mst ? !st_reg.trd : st_reg.sh[0];
              end
            end
            TW_A2: begin
              st_next.tenhit = !st_reg.mst;
              st_next.ph = TW_DAT;
              dx = st_reg.mst;
              if (st_reg.mst && st_reg.trd) begin
                st_next.eng = TW_RST;
                st_next.ph = TW_ARD;
                st_next.sh = {TW_HDR10, st_reg.tadr[9:8], 1'b1};
              end
            end
            TW_ARD: st_next.ph = TW_DAT;
            TW_DAT: begin
              dx = st_reg.xmit;
              if (st_reg.mst) st_next.nby = st_reg.nby - 8'h01;
              if (st_reg.mst && st_reg.nby <= 8'h01) st_next.eng = TW_STOP;
            end
          endcase
          if (st_next.ph == TW_DAT && st_reg.ph != TW_DAT) begin
            st_next.xmit = dx;
            if (st_reg.mst && st_reg.nby == 8'h00) st_next.eng = TW_STOP;
          end
          ld = st_next.ph == TW_DAT && st_next.xmit && st_next.eng != TW_STOP;
        end
      end
    end
    // receive store and transmit load, with stretching
    if (stall && !st_reg.hold && (st_reg.eng == TW_LOW || st_reg.eng == TW_SLV) && !st_reg.rxf) begin
      st_next.rxd = st_reg.sh;
      st_next.rxf = 1'b1;
      st_next.rcvd = 1'b1;
      st_next.rxany = 1'b1;
      ev[TW_S_RXNE] = 1'b1;
    end
    if (st_reg.hold && st_reg.txf) begin
      st_next.sh = st_reg.txd;
      st_next.txf = 1'b0;
      st_next.hold = 1'b0;
    end
    if (ld) begin
      if (PRIMARY && st_next.mst && st_reg.ctl[TW_C_PECEN] && st_next.nby == 8'h01) begin
        st_next.sh = st_next.crc;
      end else if (st_reg.txf) begin
        st_next.sh = st_reg.txd;
        st_next.txf = 1'b0;
      end else begin
        st_next.hold = 1'b1;
        ev[TW_S_TXE] = 1'b1;
      end
    end
    if (st_next.eng == TW_STOP && st_reg.eng != TW_STOP) begin
      st_next.cnt = 4'h0;
      st_next.tmr = 16'h0;
    end
    // smbus clock-low timeout
    st_next.tdiv = st_reg.tdiv + 12'h001;
    if (!st_reg.flt[0] && st_reg.busy) begin
      if (st_reg.tdiv == 12'hFFF) st_next.tcnt = st_reg.tcnt + 12'h001;
    end else begin
      st_next.tcnt = 12'h000;
    end
    if (PRIMARY && st_reg.tout != 12'h000 && st_reg.tcnt == st_reg.tout) begin
      ev[TW_S_TOUT] = 1'b1;
      st_next.tcnt = 12'h000;
      st_next.eng = TW_IDLE;
      st_next.mst = 1'b0;
      st_next.busy = 1'b0;
      st_next.scloe = 1'b0;
      st_next.sdaoe = 1'b0;
    end
    // host sees alert pin fall
    st_next.smbd = st_reg.s2[2];
    ev[TW_S_ALRT] = PRIMARY && st_reg.ctl[TW_C_HOST] && st_reg.smbd && !st_reg.s2[2];
    // apb: one wait state, register read captured before the answer
    st_next.rdy = psel && penable && !st_reg.rdy;
    st_next.err = 1'b0;
    st_next.rd = 32'h0000_0000;
    unique case (paddr)
      TW_CTRL: st_next.rd = {19'h0, st_reg.ctl[12:6], st_reg.dnf, st_reg.anf, st_reg.ctl[0]};
      TW_CMD: st_next.rd = {12'h0, st_reg.nby, st_reg.trd, st_reg.tten, st_reg.tadr};
      TW_OWN1: st_next.rd = {16'h0, st_reg.own1};
      TW_OWN2: st_next.rd = {16'h0, st_reg.own2};
      TW_TIME: st_next.rd = {16'h0, st_reg.half};
      TW_TOUT: st_next.rd = {20'h0, st_reg.tout};
      TW_STAT: st_next.rd = {11'h0, st_reg.rxf, st_reg.txf, st_reg.xmit, st_reg.mst, st_reg.busy, 7'h0, st_reg.sts};
      TW_MASK: st_next.rd = {23'h0, st_reg.msk};
      TW_RXD: st_next.rd = {24'h0, st_reg.rxd};
      TW_PEC: st_next.rd = {24'h0, st_reg.crc};
      TW_TXD: st_next.rd = {24'h0, st_reg.txd};
      default: st_next.err = 1'b1;
    endcase
    if (acc && pwrite) begin
      unique case (paddr)
        TW_CTRL: begin
          st_next.ctl = {pwdata[12:6], 5'h00, pwdata[TW_C_EN]};
          if (!PRIMARY) st_next.ctl[12:6] = {6'h00, pwdata[TW_C_WUP]} & 7'h00;
          if (!st_reg.ctl[TW_C_EN]) begin
            st_next.dnf = pwdata[TW_C_DNF +: 4];
            st_next.anf = pwdata[TW_C_ANF];
          end
          if (!pwdata[TW_C_EN]) begin
            st_next.eng = TW_IDLE;
            st_next.mst = 1'b0;
            st_next.scloe = 1'b0;
            st_next.sdaoe = 1'b0;
            st_next.hold = 1'b0;
          end
        end
        TW_CMD: begin
          if (pwdata[TW_M_GO] && st_reg.ctl[TW_C_EN] && !st_reg.busy && !st_reg.mst &&
              st_reg.eng == TW_IDLE) begin
            st_next.tadr = pwdata[9:0];
            st_next.tten = pwdata[TW_M_TEN];
            st_next.trd = pwdata[TW_M_RD];
            st_next.nby = pwdata[TW_M_NBY +: 8];
            st_next.mst = 1'b1;
            st_next.xmit = 1'b1;
            st_next.ph = TW_A1;
            st_next.eng = TW_START;
            st_next.tmr = 16'h0;
            st_next.crc = 8'h00;
            st_next.rxany = 1'b0;
            st_next.hold = 1'b0;
            st_next.sh = pwdata[TW_M_TEN] ? {TW_HDR10, pwdata[9:8], 1'b0} : {pwdata[6:0], pwdata[TW_M_RD]};
          end
        end
        TW_OWN1: st_next.own1 = pwdata[15:0];
        TW_OWN2: st_next.own2 = pwdata[15:0];
        TW_TIME: st_next.half = pwdata[15:0];
        TW_TOUT: st_next.tout = pwdata[11:0];
        TW_STAT: clr = pwdata[TW_NS-1:0];
        TW_MASK: st_next.msk = pwdata[TW_NS-1:0];
        TW_TXD: begin
          st_next.txd = pwdata[7:0];
          st_next.txf = 1'b1;
        end
        default: ;
      endcase
    end
    if (acc && !pwrite && paddr == TW_RXD && st_reg.rxf) st_next.rxf = 1'b0;
    // sticky status, set beats clear
    st_next.sts = (st_reg.sts & ~clr) | ev;
    st_next.irq = |(st_next.sts & st_reg.msk);
    st_next.dtx = st_reg.ctl[TW_C_EN] && st_reg.xmit && st_reg.ph == TW_DAT && !st_reg.txf &&
                  (st_reg.mst || st_reg.eng == TW_SLV);
    st_next.drx = st_reg.rxf;
    if (!stop_mode) st_next.wake = 1'b0;
    st_next.osc = PRIMARY && stop_mode && st_reg.ctl[TW_C_WUP] && st_reg.busy;
    st_next.fmp = PRIMARY && st_reg.ctl[TW_C_FMP];
    st_next.smbaoe = PRIMARY && st_reg.ctl[TW_C_ALRT];
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.s1 <= 3'h7;
      st_reg.s2 <= 3'h7;
      st_reg.flt <= 2'h3;
      st_reg.fltd <= 2'h3;
      st_reg.smbd <= 1'b1;
      st_reg.half <= TW_HALF_STD;
      st_reg.tout <= TW_TOUT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign prdata = st_reg.rd;
  assign pready = st_reg.rdy;
  assign pslverr = st_reg.err;
  assign scl_o = st_reg.scloe & 1'b0;
  assign sda_o = st_reg.sdaoe & 1'b0;
  assign smba_o = st_reg.smbaoe & 1'b0;
  assign scl_oe = st_reg.scloe;
  assign sda_oe = st_reg.sdaoe;
  assign smba_oe = st_reg.smbaoe;
  assign irq = st_reg.irq;
  assign dma_tx_req = st_reg.dtx;
  assign dma_rx_req = st_reg.drx;
  assign wakeup = st_reg.wake;
  assign osc_req = st_reg.osc;
  assign fmp_drive = st_reg.fmp;
  assign anf_en = st_reg.anf;

  // checks
  chk_dnf_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    $past(st_reg.dnf) == 4'h0 |-> st_reg.flt == $past(st_reg.s2[1:0])) else $error("filter not bypassed");
  chk_filt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    $past(st_reg.ctl[0]) |-> $stable(st_reg.dnf) && $stable(st_reg.anf)) else $error("filter changed while on");
  chk_spike_kill: assert property (@(posedge pclk) disable iff (!presetn)
    $past(st_reg.dnf) != 4'h0 && $changed(st_reg.flt[1]) |-> $past(st_reg.fcnt[1]) == $past(st_reg.dnf))
    else $error("spike passed filter");
  chk_fmp_only: assert property (@(posedge pclk) disable iff (!presetn)
    !PRIMARY |-> !fmp_drive && !smba_oe) else $error("secondary uses primary feature");
  chk_wake_nodnf: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wakeup) |-> $past(st_reg.dnf) == 4'h0 && $past(stop_mode)) else $error("wake with filter");
  chk_osc_stop: assert property (@(posedge pclk) disable iff (!presetn)
    osc_req |-> $past(stop_mode) && $past(st_reg.busy)) else $error("rc request outside stop");
  chk_arb_drop: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.eng == TW_HIGH && st_reg.mst && st_reg.xmit && st_reg.cnt != 4'h8 && st_reg.sh[7] &&
    !st_reg.flt[1] && st_reg.flt[0] && st_reg.tmr >= st_reg.half |=> !st_reg.mst ##1 !sda_oe)
    else $error("lost arbitration kept");
  chk_dma_rx: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_reg.rxf) |=> dma_rx_req [*1] ##0 st_reg.sts[TW_S_RXNE]) else $error("no rx dma request");
endmodule : tw_ctrl

/* verification/tw_slave_model.sv */
// Purpose: far-side target device on the two-wire bus
// Assumes: sampled on pclk, line levels already resolved
// Notes: acks its own 7-bit address and every byte after it
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h3A // own address
) (
  input wire logic clk, // sampling clock
  input wire logic scl, // clock line
  input wire logic sda, // data line
  output logic sda_oe = 1'b0, // pulls data low
  output logic [7:0] last_byte = 8'h00 // last byte taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic hit = 1'b0;
  logic first = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  // start and stop detect, bit shift, ack slot
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      cnt <= 4'h0;
      first <= 1'b1;
    end else if (scl && scl_q && !sda_q && sda) begin
      cnt <= 4'h0;
      hit <= 1'b0;
    end else if (scl && !scl_q && cnt < 4'h8) begin
      sh <= {sh[6:0], sda};
      cnt <= cnt + 4'h1;
    end else if (!scl && scl_q && cnt == 4'h8) begin
      hit <= first ? (sh[7:1] == ADDR) : hit;
      sda_oe <= first ? (sh[7:1] == ADDR) : hit;
      last_byte <= first ? last_byte : sh;
      first <= 1'b0;
      cnt <= 4'h9;
    end else if (!scl && scl_q && cnt == 4'h9) begin
      sda_oe <= 1'b0;
      cnt <= 4'h0;
    end
  end
endmodule : tw_slave_model

/* verification/tb_top.sv */
// Purpose: self-checking bench of the two-wire controller
// Assumes: open-drain lines with pull-ups, 4 ns pclk
// Notes: register table first, then master transfers
`define CHK(n, x, g) begin num_checks++; if ((g) !== (x)) begin failures++; $display("FAIL %s exp %h got %h", n, x, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tw_pkg::*;
  typedef struct {bit w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} tw_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, scl_oe, sda_oe, smba_oe, m_oe, irq, fmp_drive, anf_en;
  logic dma_tx_req, dma_rx_req, wakeup, osc_req;
  logic stop_mode = 1'b0;
  logic [7:0] got;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | m_oe);
  wire smba = ~smba_oe;
  int failures = 0;
  int num_checks = 0;
  tw_row_t rows [12] = '{
    '{1'b0, TW_TIME, 32'h0, 32'h4E2, 1'b0},
    '{1'b0, TW_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b1, TW_MASK, 32'h1FF, 32'h0, 1'b0},
    '{1'b0, TW_MASK, 32'h0, 32'h1FF, 1'b0},
    '{1'b0, 12'h0FC, 32'h0, 32'h0, 1'b1},
    '{1'b1, TW_CTRL, 32'h4F, 32'h0, 1'b0},
    '{1'b1, TW_CTRL, 32'h43, 32'h0, 1'b0},
    '{1'b0, TW_CTRL, 32'h0, 32'h4F, 1'b0},
    '{1'b1, TW_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, TW_CTRL, 32'h0, 32'h0E, 1'b0},
    '{1'b1, TW_CTRL, 32'h43, 32'h0, 1'b0},
    '{1'b0, TW_CTRL, 32'h0, 32'h43, 1'b0}};
  tw_ctrl #(.PRIMARY(1'b1)) tw_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .smba_i(smba),
    .smba_o(), .smba_oe(smba_oe), .stop_mode(stop_mode), .irq(irq), .dma_tx_req(dma_tx_req),
    .dma_rx_req(dma_rx_req), .wakeup(wakeup), .osc_req(osc_req), .fmp_drive(fmp_drive), .anf_en(anf_en));
  tw_slave_model tw_slave_model_inst (.clk(pclk), .scl(scl), .sda(sda), .sda_oe(m_oe), .last_byte(got));
  // free-running peripheral clock
  always #2 pclk = ~pclk;
  task automatic end_sim;
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      end_sim();
    end
  endtask : apb
  // poll status until a bit sets; a spent bound ends the run
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, TW_STAT, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 2000);
    if (rd[b] !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask : poll
  // one-byte master write, then poll for the stop flag
  task automatic xfer(input logic [6:0] a, input logic [7:0] d, input logic nack);
    apb(1'b1, TW_TXD, {24'h0, d});
    apb(1'b1, TW_CMD, 32'h0010_1000 | {25'h0, a});
    poll(TW_S_STOP);
    `CHK("stop", 1'b1, rd[TW_S_STOP])
    `CHK("nack", nack, rd[TW_S_NACK])
    `CHK("irq", 1'b1, irq)
  endtask : xfer
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK("err", rows[i].e, er)
      if (!rows[i].w) `CHK("reg", rows[i].x, rd)
    end
    `CHK("fmp", 1'b1, fmp_drive)
    `CHK("anf", 1'b1, anf_en)
    `CHK("alert", 1'b0, smba_oe)
    apb(1'b1, TW_TIME, 32'h6);
    xfer(7'h3A, 8'hA5, 1'b0);
    `CHK("byte", 8'hA5, got)
    apb(1'b1, TW_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK("masked", 1'b0, irq)
    apb(1'b1, TW_MASK, 32'h1FF);
    apb(1'b1, TW_STAT, 32'h1FF);
    apb(1'b0, TW_STAT, 32'h0);
    `CHK("w1c", 9'h0, rd[8:0])
    xfer(7'h21, 8'h5A, 1'b1);
    `CHK("idle", 1'b1, scl)
    // two-byte write in stop mode, second byte late: clock held, dma asked
    stop_mode <= 1'b1;
    apb(1'b1, TW_CTRL, 32'hC3);
    apb(1'b1, TW_STAT, 32'h1FF);
    apb(1'b1, TW_TXD, 32'h11);
    apb(1'b1, TW_CMD, 32'h0010_203A);
    poll(TW_S_TXE);
    `CHK("dtx", 1'b1, dma_tx_req)
    `CHK("osc", 1'b1, osc_req)
    `CHK("wake", 1'b0, wakeup)
    `CHK("held", 1'b0, scl)
    apb(1'b1, TW_TXD, 32'h22);
    poll(TW_S_STOP);
    `CHK("byte2", 8'h22, got)
    stop_mode <= 1'b0;
    // filtered one-byte read of the released line
    apb(1'b1, TW_CTRL, 32'h0);
    apb(1'b1, TW_CTRL, 32'h4F);
    apb(1'b1, TW_STAT, 32'h1FF);
    apb(1'b1, TW_CMD, 32'h0010_183A);
    poll(TW_S_STOP);
    `CHK("drx", 1'b1, dma_rx_req)
    apb(1'b0, TW_RXD, 32'h0);
    `CHK("rxd", 32'hFF, rd)
    repeat (2) @(posedge pclk);
    `CHK("drx0", 1'b0, dma_rx_req)
    // mid-run reset brings back the default bit time
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TW_TIME, 32'h0);
    `CHK("rst_time", {16'h0, TW_HALF_STD}, rd)
    `CHK("rst_anf", 1'b0, anf_en)
    end_sim();
  end
endmodule : tb_top
